// ==== hdl/fsa_defines.vh ====
// timing constants for the center-aligned pwm and adc trigger core
// assumes a 200 mhz core clock
`ifndef FSA_DEFINES_VH
`define FSA_DEFINES_VH
`define FSA_CLK_MHZ 200
`define FSA_CARRIER_HZ 10000
`define FSA_CTRL_PERIOD_US 100
// half carrier in clocks: up-down counter peak
`define FSA_HALF_PERIOD (`FSA_CLK_MHZ * 1000000 / `FSA_CARRIER_HZ / 2)
`define FSA_TRIG_LEAD_NS 500
`define FSA_TRIG_LEAD_CYC ((`FSA_TRIG_LEAD_NS * `FSA_CLK_MHZ + 999) / 1000)
`define FSA_DEAD_NS 800
`define FSA_DEAD_CYC ((`FSA_DEAD_NS * `FSA_CLK_MHZ + 999) / 1000)
`define FSA_DUTY_W 16
`define FSA_ADC_CHANNELS 4
`define FSA_CH_CUR_A 2'h0
`define FSA_CH_CUR_B 2'h1
`define FSA_CH_VBUS 2'h2
`define FSA_CH_SPEED 2'h3
`endif

// ==== hdl/fsa_phase.v ====
// one complementary phase leg with dead time
// assumes compare flag from the shared carrier, same clock
module fsa_phase #(
	parameter DEAD_CYC = 160
) (
	// clock and reset
	input wire core_clk,
	input wire rst_b,
	// control
	input wire on_req,
	input wire kill,
	// gate drive
	output reg hi_reg,
	output reg lo_reg
);
	reg [15:0] dead_reg;
	reg want_reg;
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			hi_reg <= 1'b0;
			lo_reg <= 1'b0;
			dead_reg <= 16'h0000;
			want_reg <= 1'b0;
		end else if (kill) begin
			hi_reg <= 1'b0;
			lo_reg <= 1'b0;
			dead_reg <= DEAD_CYC[15:0];
			want_reg <= on_req;
		end else if (on_req != want_reg) begin
			// both off first, never an overlap
			hi_reg <= 1'b0;
			lo_reg <= 1'b0;
			want_reg <= on_req;
			dead_reg <= DEAD_CYC[15:0];
		end else if (dead_reg != 16'h0000) begin
			dead_reg <= dead_reg - 16'h0001;
		end else begin
			hi_reg <= want_reg;
			lo_reg <= ~want_reg;
		end
	end
endmodule

// ==== hdl/fsa_core.v ====
// center-aligned three-phase pwm, adc trigger, overcurrent trip, switch inputs
// assumes pins are asynchronous, duty words from logic on core_clk
// Function
// - three complementary center-aligned phase pwm pairs
// - new duties accepted every carrier period
// - adc trigger 0.5us before underflow
// - one adc scan per carrier period
// - scan current a, current b, bus, speed
// - one underflow per period raises interrupt
// - high and low never both on
// - comparator trips on dac threshold
// - start/stop switch enables or locks motor
// - direction button toggles running direction
`include "fsa_defines.vh"
module fsa_core #(
	parameter HALF_PERIOD = `FSA_HALF_PERIOD,
	parameter TRIG_LEAD = `FSA_TRIG_LEAD_CYC,
	parameter DEAD_CYC = `FSA_DEAD_CYC,
	parameter DAC_W = 8,
	parameter [DAC_W-1:0] DAC_RESET = 8'h80
) (
	// clock and reset
	input wire core_clk,
	input wire rst_b,
	// duty words from control software
	input wire [15:0] duty_a,
	input wire [15:0] duty_b,
	input wire [15:0] duty_c,
	input wire duty_load,
	// fault control
	input wire [DAC_W-1:0] oc_threshold,
	input wire fault_clear,
	// pins
	input wire overcurrent_comparator,
	input wire start_switch,
	input wire direction_button,
	// gate drive
	output reg gate_a_hi,
	output reg gate_a_lo,
	output reg gate_b_hi,
	output reg gate_b_lo,
	output reg gate_c_hi,
	output reg gate_c_lo,
	// events
	output reg carrier_underflow,
	output reg adc_trigger_compare,
	output reg adc_start,
	output reg [1:0] adc_channel,
	output reg adc_scan_done,
	// status
	output reg [DAC_W-1:0] overcurrent_threshold_dac,
	output reg fault_reg,
	output reg run_reg,
	output reg dir_reg
);
	reg [15:0] cnt_reg;
	reg up_reg;
	reg [15:0] act_a_reg;
	reg [15:0] act_b_reg;
	reg [15:0] act_c_reg;
	reg [15:0] sh_a_reg;
	reg [15:0] sh_b_reg;
	reg [15:0] sh_c_reg;
	reg [2:0] oc_sync_reg;
	reg [2:0] ss_sync_reg;
	reg [2:0] db_sync_reg;
	reg db_level_reg;
	wire oc_trip;
	wire db_rise;
	reg [15:0] cnt_next;
	reg up_next;
	wire on_a;
	wire on_b;
	wire on_c;
	wire a_hi;
	wire a_lo;
	wire b_hi;
	wire b_lo;
	wire c_hi;
	wire c_lo;
	wire kill;

	function [15:0] clamp_duty;
		input [15:0] d;
		begin
			clamp_duty = (d > HALF_PERIOD[15:0]) ? HALF_PERIOD[15:0] : d;
		end
	endfunction

	// a change counts once second and third stage agree
	function agreed;
		input [2:0] s;
		input prev;
		begin
			agreed = (s[1] == s[2]) ? s[2] : prev;
		end
	endfunction

	// drive request: on while the carrier is below the duty
	function phase_on;
		input [15:0] count;
		input [15:0] duty;
		begin
			phase_on = (count < duty);
		end
	endfunction

	// direction swaps which duty feeds phases b and c
	function [15:0] pick_duty;
		input swap;
		input [15:0] own;
		input [15:0] other;
		begin
			pick_duty = swap ? other : own;
		end
	endfunction

	localparam ST_IDLE = 3'b001;
	localparam ST_SCAN = 3'b010;
	localparam ST_DONE = 3'b100;
	reg [2:0] st_reg;

	// up-down carrier, underflow at zero
	// peak is HALF_PERIOD itself, so a period is 2*HALF_PERIOD clocks
	always @* begin
		up_next = up_reg;
		if (up_reg && cnt_reg == HALF_PERIOD[15:0] - 16'h0001)
			up_next = 1'b0;
		else if (!up_reg && cnt_reg == 16'h0001)
			up_next = 1'b1;
		if (up_reg)
			cnt_next = cnt_reg + 16'h0001;
		else
			cnt_next = cnt_reg - 16'h0001;
	end

	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_reg <= 16'h0001;
			up_reg <= 1'b1;
			carrier_underflow <= 1'b0;
			adc_trigger_compare <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			up_reg <= up_next;
			// exactly once per period
			carrier_underflow <= (cnt_next == 16'h0000);
			// lead point on the down slope
			adc_trigger_compare <= !up_next && (cnt_next == TRIG_LEAD[15:0]);
		end
	end

	// shadow then activate at underflow
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			sh_a_reg <= 16'h0000;
			sh_b_reg <= 16'h0000;
			sh_c_reg <= 16'h0000;
			act_a_reg <= 16'h0000;
			act_b_reg <= 16'h0000;
			act_c_reg <= 16'h0000;
		end else begin
			if (duty_load) begin
				sh_a_reg <= clamp_duty(duty_a);
				sh_b_reg <= clamp_duty(duty_b);
				sh_c_reg <= clamp_duty(duty_c);
			end
			// a load in the underflow cycle goes straight to the active set
			if (cnt_reg == 16'h0000) begin
				act_a_reg <= duty_load ? clamp_duty(duty_a) : sh_a_reg;
				act_b_reg <= duty_load ? clamp_duty(duty_b) : sh_b_reg;
				act_c_reg <= duty_load ? clamp_duty(duty_c) : sh_c_reg;
			end
		end
	end

	// pin synchronisers
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			oc_sync_reg <= 3'h0;
			ss_sync_reg <= 3'h0;
			db_sync_reg <= 3'h0;
			db_level_reg <= 1'b0;
			run_reg <= 1'b0;
		end else begin
			oc_sync_reg <= {oc_sync_reg[1:0], overcurrent_comparator};
			ss_sync_reg <= {ss_sync_reg[1:0], start_switch};
			db_sync_reg <= {db_sync_reg[1:0], direction_button};
			db_level_reg <= agreed(db_sync_reg, db_level_reg);
			run_reg <= agreed(ss_sync_reg, run_reg);
		end
	end

	// comparator high means bus current above dac threshold
	assign oc_trip = (oc_sync_reg[1] == oc_sync_reg[2]) && oc_sync_reg[2];
	assign db_rise = (db_sync_reg[1] == db_sync_reg[2]) && db_sync_reg[2] && !db_level_reg;

	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			fault_reg <= 1'b0;
			dir_reg <= 1'b0;
			overcurrent_threshold_dac <= DAC_RESET;
		end else begin
			overcurrent_threshold_dac <= oc_threshold;
			// trip wins over a clear in the same cycle
			if (oc_trip)
				fault_reg <= 1'b1;
			else if (fault_clear)
				fault_reg <= 1'b0;
			if (db_rise)
				dir_reg <= ~dir_reg;
		end
	end

	// gates off on fault or when the switch locks the motor
	// trip taken straight from the synchroniser, a cycle ahead of the flag
	assign kill = fault_reg || oc_trip || !run_reg;

	// phase on while counter is below duty: centered on the underflow
	// a duty clamped to the peak still drops for one cycle there, plus dead time
	assign on_a = phase_on(cnt_reg, act_a_reg);
	assign on_b = phase_on(cnt_reg, pick_duty(dir_reg, act_b_reg, act_c_reg));
	assign on_c = phase_on(cnt_reg, pick_duty(dir_reg, act_c_reg, act_b_reg));

	fsa_phase #(.DEAD_CYC(DEAD_CYC)) u_pa (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.on_req(on_a),
		.kill(kill),
		.hi_reg(a_hi),
		.lo_reg(a_lo)
	);

	fsa_phase #(.DEAD_CYC(DEAD_CYC)) u_pb (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.on_req(on_b),
		.kill(kill),
		.hi_reg(b_hi),
		.lo_reg(b_lo)
	);

	fsa_phase #(.DEAD_CYC(DEAD_CYC)) u_pc (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.on_req(on_c),
		.kill(kill),
		.hi_reg(c_hi),
		.lo_reg(c_lo)
	);

	// outputs registered, immediate kill overrides
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			gate_a_hi <= 1'b0;
			gate_a_lo <= 1'b0;
			gate_b_hi <= 1'b0;
			gate_b_lo <= 1'b0;
			gate_c_hi <= 1'b0;
			gate_c_lo <= 1'b0;
		end else begin
			gate_a_hi <= a_hi && !kill;
			gate_a_lo <= a_lo && !kill;
			gate_b_hi <= b_hi && !kill;
			gate_b_lo <= b_lo && !kill;
			gate_c_hi <= c_hi && !kill;
			gate_c_lo <= c_lo && !kill;
		end
	end

	// adc scan sequencer: one scan of four channels per trigger
	// the next trigger is a full carrier away, so scans never overlap
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg <= ST_IDLE;
			adc_start <= 1'b0;
			adc_channel <= `FSA_CH_CUR_A;
			adc_scan_done <= 1'b0;
		end else begin
			adc_start <= 1'b0;
			adc_scan_done <= 1'b0;
			case (st_reg)
			ST_IDLE: begin
				if (adc_trigger_compare) begin
					adc_channel <= `FSA_CH_CUR_A;
					adc_start <= 1'b1;
					st_reg <= ST_SCAN;
				end
			end
			ST_SCAN: begin
				if (adc_channel == `FSA_CH_SPEED) begin
					st_reg <= ST_DONE;
				end else begin
					adc_channel <= adc_channel + 2'h1;
					adc_start <= 1'b1;
				end
			end
			ST_DONE: begin
				adc_scan_done <= 1'b1;
				st_reg <= ST_IDLE;
			end
			default: st_reg <= ST_IDLE;
			endcase
		end
	end
endmodule

// ==== test/fsa_drive_model.sv ====
// gate driver and shunt sense stand-in facing the pwm core
// assumes active high gates; the bench raises short_req to fake a fault
module fsa_drive_model (
	// gate drive
	input wire gate_a_hi,
	input wire gate_b_hi,
	input wire gate_c_hi,
	// bench control
	input wire short_req,
	// comparator pin
	output wire overcurrent_comparator
);
	timeunit 1ns;
	timeprecision 100ps;
	// a shorted leg draws current only while some high side conducts
	assign overcurrent_comparator = short_req & (gate_a_hi | gate_b_hi | gate_c_hi);
endmodule

// ==== test/fsa_core_assertions.sv ====
// carrier event and gate safety checker for the pwm core
// assumes bound into fsa_core, everything on core_clk
module fsa_core_assertions #(
	parameter int HALF_PERIOD = 100,
	parameter int TRIG_LEAD = 10
) (
	// clock and reset
	input wire core_clk,
	input wire rst_b,
	// fault
	input wire fault_clear,
	input wire overcurrent_comparator,
	input wire fault_reg,
	input wire run_reg,
	// gates
	input wire gate_a_hi,
	input wire gate_a_lo,
	input wire gate_b_hi,
	input wire gate_b_lo,
	input wire gate_c_hi,
	input wire gate_c_lo,
	// events
	input wire carrier_underflow,
	input wire adc_trigger_compare,
	input wire adc_start,
	input wire [1:0] adc_channel,
	input wire adc_scan_done
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam int PER = 2 * HALF_PERIOD;
	wire any_g = gate_a_hi | gate_a_lo | gate_b_hi | gate_b_lo | gate_c_hi | gate_c_lo;
	// clocks since the last underflow, one in the cycle after it
	int unsigned uf_gap;
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			uf_gap <= 1;
		else if (carrier_underflow)
			uf_gap <= 1;
		else
			uf_gap <= uf_gap + 1;
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	chk_uf_period: assert property (carrier_underflow == (uf_gap == PER))
		else $error("underflow spacing wrong");
	chk_trig_lead: assert property (adc_trigger_compare |-> ##TRIG_LEAD carrier_underflow)
		else $error("trigger lead wrong");
	chk_scan_order: assert property (adc_trigger_compare |=>
		adc_start && adc_channel == 2'h0 ##1 adc_start && adc_channel == 2'h1
		##1 adc_start && adc_channel == 2'h2 ##1 adc_start && adc_channel == 2'h3
		##1 !adc_start ##[0:1] adc_scan_done) else $error("scan order wrong");
	chk_no_shoot: assert property (!(gate_a_hi && gate_a_lo) && !(gate_b_hi && gate_b_lo)
		&& !(gate_c_hi && gate_c_lo)) else $error("shoot through");
	chk_trip_sets: assert property ($rose(overcurrent_comparator) |-> ##[1:6] fault_reg)
		else $error("trip missed");
	chk_fault_dark: assert property (fault_reg [*2] |-> !any_g)
		else $error("gate on in fault");
	chk_fault_hold: assert property (fault_reg && !fault_clear |=> fault_reg)
		else $error("fault dropped");
	chk_run_lock: assert property (!run_reg [*2] |-> !any_g)
		else $error("gate on while stopped");
endmodule
bind fsa_core fsa_core_assertions #(.HALF_PERIOD(HALF_PERIOD), .TRIG_LEAD(TRIG_LEAD)) u_chk (
	.core_clk(core_clk), .rst_b(rst_b), .fault_clear(fault_clear),
	.overcurrent_comparator(overcurrent_comparator), .fault_reg(fault_reg), .run_reg(run_reg),
	.gate_a_hi(gate_a_hi), .gate_a_lo(gate_a_lo), .gate_b_hi(gate_b_hi),
	.gate_b_lo(gate_b_lo), .gate_c_hi(gate_c_hi), .gate_c_lo(gate_c_lo),
	.carrier_underflow(carrier_underflow), .adc_trigger_compare(adc_trigger_compare),
	.adc_start(adc_start), .adc_channel(adc_channel), .adc_scan_done(adc_scan_done));

// ==== test/fsa_core_tb_top.sv ====
// self-checking bench for the pwm core with the drive stand-in
// assumes a shortened carrier; timing counted in core_clk cycles, except the watchdog, which is in ns
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin bad_count++; \
	$display("ERROR %s expected %0d seen %0d", n, e, s); end end
module fsa_core_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int HP = 100;
	localparam int TL = 10;
	localparam int DC = 4;
	localparam int PER = 2 * HP;
	localparam int DA = 50;
	logic core_clk = 0, rst_b = 0, duty_load = 0, fault_clear = 0;
	logic start_switch = 0, direction_button = 0, short_req = 0;
	logic [15:0] duty_a = 16'h0000, duty_b = 16'h0000, duty_c = 16'h0000;
	logic [7:0] oc_threshold = 8'h3c;
	wire cmp, ah, al, bh, bl, ch, cl, uf, trg, ast, done, fault, run, dir;
	wire [1:0] chan;
	wire [7:0] dac;
	int bad_count = 0, comparisons = 0, cnt[9], ti;
	logic [3:0] seen;
	always #2.5 core_clk = ~core_clk;
	fsa_core #(.HALF_PERIOD(HP), .TRIG_LEAD(TL), .DEAD_CYC(DC)) DUT (.core_clk(core_clk),
		.rst_b(rst_b), .duty_a(duty_a), .duty_b(duty_b), .duty_c(duty_c), .duty_load(duty_load),
		.oc_threshold(oc_threshold), .fault_clear(fault_clear), .overcurrent_comparator(cmp),
		.start_switch(start_switch), .direction_button(direction_button), .gate_a_hi(ah),
		.gate_a_lo(al), .gate_b_hi(bh), .gate_b_lo(bl), .gate_c_hi(ch), .gate_c_lo(cl),
		.carrier_underflow(uf), .adc_trigger_compare(trg), .adc_start(ast), .adc_channel(chan),
		.adc_scan_done(done), .overcurrent_threshold_dac(dac), .fault_reg(fault), .run_reg(run),
		.dir_reg(dir));
	fsa_drive_model drv (.gate_a_hi(ah), .gate_b_hi(bh), .gate_c_hi(ch), .short_req(short_req),
		.overcurrent_comparator(cmp));
	task automatic step(int n = 1);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// one full carrier period, index 0 at the underflow cycle
	task automatic period;
		int i;
		logic [8:0] v;
		for (i = 0; i < 400 && uf !== 1'b1; i++) step();
		cnt = '{default: 0};
		seen = 4'h0;
		ti = -1;
		for (i = 0; i < PER; i++) begin
			v = {done, uf, ast, ah, al, bh, bl, ch, cl};
			foreach (cnt[j]) cnt[j] += v[j];
			if (ast === 1'b1) seen[chan] = 1'b1;
			if (trg === 1'b1) ti = i;
			step();
		end
	endtask
	function automatic int gsum;
		return cnt[0] + cnt[1] + cnt[2] + cnt[3] + cnt[4] + cnt[5];
	endfunction
	task automatic load(logic [15:0] a, logic [15:0] b, logic [15:0] c);
		@(posedge core_clk) {duty_a, duty_b, duty_c, duty_load} <= {a, b, c, 1'b1};
		@(posedge core_clk) duty_load <= 1'b0;
		period();
		period();
	endtask
	task automatic t_events;
		period();
		`CHK("underflows", 1, cnt[7])
		`CHK("trigger index", PER - TL, ti)
		`CHK("adc starts", 4, cnt[6])
		`CHK("scan done", 1, cnt[8])
		`CHK("channels", 4'hf, seen)
		$display("events done");
	endtask
	task automatic t_duty;
		// a on for 2*DA-1 clocks; each change is both-off for DC+1 clocks
		// b clamps to the peak value and so drops once at the peak
		load(16'(DA), 16'hffff, 16'h0000);
		`CHK("a hi", 2 * DA - 1 - (DC + 1), cnt[5])
		`CHK("a lo", PER - 2 * DA + 1 - (DC + 1), cnt[4])
		`CHK("b hi", PER - (DC + 2), cnt[3])
		`CHK("b lo", 0, cnt[2])
		`CHK("c lo", PER, cnt[0])
		load(16'h0000, 16'hffff, 16'h0000);
		`CHK("a hi new", 0, cnt[5])
		`CHK("a lo new", PER, cnt[4])
		$display("duty done");
	endtask
	task automatic t_dir;
		// held long to get past the pin debounce
		@(posedge core_clk) direction_button <= 1'b1;
		step(300);
		@(posedge core_clk) direction_button <= 1'b0;
		step(300);
		`CHK("dir", 1'b1, dir)
		period();
		period();
		`CHK("c hi swapped", PER - (DC + 2), cnt[1])
		`CHK("b hi swapped", 0, cnt[3])
		$display("direction done");
	endtask
	task automatic t_fault;
		int i;
		@(posedge core_clk) short_req <= 1'b1;
		for (i = 0; i < 50 && fault !== 1'b1; i++) step();
		`CHK("fault set", 1'b1, fault)
		`CHK("dac", 8'h3c, dac)
		@(posedge core_clk) short_req <= 1'b0;
		period();
		`CHK("gates in fault", 0, gsum())
		`CHK("fault held", 1'b1, fault)
		@(posedge core_clk) fault_clear <= 1'b1;
		@(posedge core_clk) fault_clear <= 1'b0;
		step(4);
		`CHK("fault cleared", 1'b0, fault)
		$display("fault done");
	endtask
	task automatic t_stop;
		@(posedge core_clk) start_switch <= 1'b0;
		step(300);
		period();
		`CHK("run off", 1'b0, run)
		`CHK("gates stopped", 0, gsum())
		$display("stop done");
	endtask
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge core_clk);
		rst_b <= 1'b1;
		start_switch <= 1'b1;
		step(300);
		`CHK("run on", 1'b1, run)
		t_events();
		t_duty();
		t_dir();
		t_fault();
		t_stop();
		stop_test();
	end
	// run needs roughly 4000 cycles; this is about ten times that
	initial begin
		#200000;
		bad_count++;
		stop_test();
	end
endmodule
